// ---- eeb_cell_array.sv ----
`timescale 1ns/100ps
`include "eeb_map.svh"

module eeb_cell_array
   import eeb_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   wr_en,
   input  wire eeb_mode_e              wr_mode,
   input  wire logic [`EEB_ADDR_W-1:0] wr_addr,
   input  wire logic [7:0]             wr_data,
   input  wire logic [`EEB_ADDR_W-1:0] rd_addr,
   output logic      [7:0]             rd_data
);

   logic [7:0] mem [0:`EEB_DEPTH-1];
   logic [7:0] cell_d;

   // new cell content per programming mode
   always_comb begin
      cell_d = mem[wr_addr];
      unique case (wr_mode)
         EEB_PM_ATOMIC: cell_d = wr_data;
         EEB_PM_ERASE:  cell_d = `EEB_BYTE_ERASED;
         EEB_PM_WRITE:  cell_d = mem[wr_addr] & wr_data; // write only clears bits
         EEB_PM_RSV:    cell_d = mem[wr_addr];
      endcase
   end

   // cell update at end of programming
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= cell_d;
      end
   end

   // read port, data available at once
   assign rd_data = mem[rd_addr];

endmodule

// ---- eeb_controller.sv ----
// Overview of operation
// - a read halts the cpu for four clock cycles.
// - a started write halts the cpu for two clock cycles.
// - address bits 9..0 select a byte; reserved address and control bits read zero.
// - data register holds byte to program, and after read the fetched byte.
// - mode bits select atomic, erase only or write only; code 11 reserved.
// - mode bit writes are ignored while the write strobe is set.
// - reset clears mode bits unless programming is still running.
// - ready interrupt is a level while strobe clear, never during write or flash programming.
// - master write enable clears itself four cycles after software sets it.
// - strobe starts a write only while master write enable is one.
// - strobe clears by hardware when programming time has elapsed.
// - read strobe fetches data into the data register at once.
// - during a write reads are refused and only reset can change the address.
// - programming time is counted in rc oscillator cycles, 26368 for atomic.
// - a write in progress survives reset and completes.
`timescale 1ns/100ps
`include "eeb_map.svh"

module eeb_controller
   import eeb_pkg::*;
#(
   parameter int PROG_RC_ATOMIC = `EEB_RC_CYCLES,
   parameter int PROG_RC_SPLIT  = `EEB_RC_CYCLES * `EEB_T_SPLIT_US / `EEB_T_ATOMIC_US
)
(
   input  wire logic                   clock,
   input  wire logic                   srst,
   input  wire logic [`EEB_IO_AW-1:0]  io_addr,
   input  wire logic                   io_wr,
   input  wire logic                   io_rd,
   input  wire logic [7:0]             io_wdata,
   output logic      [7:0]             io_rdata,
   output logic                        cpu_stall,
   input  wire logic                   global_int_enable,
   input  wire logic                   flash_selfprog_active,
   input  wire logic                   rc_osc,
   output logic                        ready_irq
);

   // register address compare
   function automatic logic reg_hit(input logic [`EEB_IO_AW-1:0] a, input logic [`EEB_IO_AW-1:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   logic [`EEB_ADDR_W-1:0]  addr_q,     addr_d;
   logic [7:0]              data_q,     data_d;
   eeb_mode_e               pm_q,       pm_d;
   logic                    rie_q,      rie_d;
   logic                    mwe_q,      mwe_d;
   logic [2:0]              mwe_cnt_q,  mwe_cnt_d;
   logic [2:0]              stall_q,    stall_d;
   eeb_state_e              state_q,    state_d;
   logic [`EEB_PCNT_W-1:0]  pcnt_q,     pcnt_d;
   logic [`EEB_ADDR_W-1:0]  op_addr_q,  op_addr_d;
   logic [7:0]              op_data_q,  op_data_d;
   eeb_mode_e               op_mode_q,  op_mode_d;
   logic [7:0]              rdata_q,    rdata_d;
   logic                    rc_s1_q,    rc_s2_q,  rc_s3_q;
   logic                    rc_lvl_q,   rc_lvl_d;
   logic                    ctl_wr, busy, wr_req, wr_start, rd_start, rc_edge, prog_done;
   logic [7:0]              mem_rdata;
   logic [7:0]              ctl_view;

   // decoded strobes
   assign ctl_wr    = io_wr && reg_hit(io_addr, `EEB_OFS_CTRL);
   assign busy      = (state_q == EEB_PROG);
   assign wr_req    = ctl_wr && io_wdata[`EEB_BIT_WE];
   assign wr_start  = wr_req && mwe_q && !busy && !flash_selfprog_active
                      && (pm_q != EEB_PM_RSV);
   assign rd_start  = ctl_wr && io_wdata[`EEB_BIT_RE] && !busy;
   assign rc_edge   = rc_lvl_d && !rc_lvl_q;
   assign prog_done = busy && rc_edge && (pcnt_q == `EEB_PCNT_ONE);

   // rc oscillator synchroniser, change taken when stages two and three agree
   always_comb begin
      rc_lvl_d = rc_lvl_q;
      if (rc_s2_q == rc_s3_q) begin
         rc_lvl_d = rc_s3_q;
      end
   end

   always_ff @(posedge clock) begin
      rc_s1_q  <= rc_osc;
      rc_s2_q  <= rc_s1_q;
      rc_s3_q  <= rc_s2_q;
      rc_lvl_q <= rc_lvl_d; // no reset: a false edge would shorten a write that runs through reset
   end

   // programming engine, runs on through reset
   always_comb begin
      state_d   = state_q;
      pcnt_d    = pcnt_q;
      op_addr_d = op_addr_q;
      op_data_d = op_data_q;
      op_mode_d = op_mode_q;
      unique case (state_q)
         EEB_IDLE: begin
            if (wr_start && !srst) begin
               state_d   = EEB_PROG;
               op_addr_d = addr_q;
               op_data_d = data_q;
               op_mode_d = pm_q;
               pcnt_d    = (pm_q == EEB_PM_ATOMIC) ? `EEB_PCNT_W'(PROG_RC_ATOMIC)
                                                   : `EEB_PCNT_W'(PROG_RC_SPLIT);
            end
         end
         EEB_PROG: begin
            if (rc_edge) begin
               pcnt_d = pcnt_q - `EEB_PCNT_ONE;
            end
            if (prog_done) begin
               state_d = EEB_IDLE;
            end
         end
      endcase
      // reset parks an idle or unknown engine; a running write carries on
      if (srst) begin
         if (busy) begin
            state_d = state_d;
         end else begin
            state_d = EEB_IDLE;
         end
      end
   end

   always_ff @(posedge clock) begin
      state_q   <= state_d;
      pcnt_q    <= pcnt_d;
      op_addr_q <= op_addr_d;
      op_data_q <= op_data_d;
      op_mode_q <= op_mode_d;
   end

   // software visible control and data registers
   always_comb begin
      addr_d    = addr_q;
      data_d    = data_q;
      pm_d      = pm_q;
      rie_d     = rie_q;
      mwe_d     = mwe_q;
      mwe_cnt_d = mwe_cnt_q;
      stall_d   = stall_q;
      if (stall_q != `EEB_CNT3_ZERO) begin
         stall_d = stall_q - `EEB_CNT3_ONE;
      end
      if (mwe_cnt_q != `EEB_CNT3_ZERO) begin
         mwe_cnt_d = mwe_cnt_q - `EEB_CNT3_ONE;
         if (mwe_cnt_q == `EEB_CNT3_ONE) begin
            mwe_d = 1'b0;
         end
      end
      if (io_wr && !busy && reg_hit(io_addr, `EEB_OFS_ADDR_LO)) begin
         addr_d[7:0] = io_wdata;
      end
      if (io_wr && !busy && reg_hit(io_addr, `EEB_OFS_ADDR_HI)) begin
         addr_d[`EEB_ADDR_W-1:8] = io_wdata[`EEB_HI_BITS-1:0];
      end
      if (io_wr && reg_hit(io_addr, `EEB_OFS_DATA)) begin
         data_d = io_wdata;
      end
      if (ctl_wr) begin
         rie_d = io_wdata[`EEB_BIT_RIE];
         if (!busy) begin
            pm_d = eeb_mode_e'(io_wdata[`EEB_PM_MSB:`EEB_PM_LSB]);
         end
         if (io_wdata[`EEB_BIT_MWE]) begin
            mwe_d     = 1'b1;
            mwe_cnt_d = `EEB_MWE_TIMEOUT;
         end else begin
            mwe_d     = 1'b0;
            mwe_cnt_d = `EEB_CNT3_ZERO;
         end
      end
      if (rd_start) begin
         data_d  = mem_rdata;
         stall_d = `EEB_READ_STALL;
      end
      if (wr_start) begin
         stall_d = `EEB_WRITE_STALL;
      end
      if (srst) begin
         addr_d    = `EEB_ADDR_RST;
         data_d    = `EEB_BYTE_ZERO;
         rie_d     = 1'b0;
         mwe_d     = 1'b0;
         mwe_cnt_d = `EEB_CNT3_ZERO;
         stall_d   = `EEB_CNT3_ZERO;
         if (!busy) begin
            pm_d = eeb_mode_e'(`EEB_PM_RST);
         end
      end
   end

   always_ff @(posedge clock) begin
      addr_q    <= addr_d;
      data_q    <= data_d;
      pm_q      <= pm_d;
      rie_q     <= rie_d;
      mwe_q     <= mwe_d;
      mwe_cnt_q <= mwe_cnt_d;
      stall_q   <= stall_d;
   end

   // register read mux, reserved bits zero
   assign ctl_view = {2'b00, pm_q, rie_q, mwe_q, busy, 1'b0};

   always_comb begin
      rdata_d = `EEB_BYTE_ZERO;
      if (io_rd && !srst) begin
         if (reg_hit(io_addr, `EEB_OFS_CTRL)) begin
            rdata_d = ctl_view;
         end else if (reg_hit(io_addr, `EEB_OFS_DATA)) begin
            rdata_d = data_q;
         end else if (reg_hit(io_addr, `EEB_OFS_ADDR_LO)) begin
            rdata_d = addr_q[7:0];
         end else if (reg_hit(io_addr, `EEB_OFS_ADDR_HI)) begin
            rdata_d = {6'h00, addr_q[`EEB_ADDR_W-1:8]};
         end
      end
   end

   always_ff @(posedge clock) begin
      rdata_q <= rdata_d;
   end

   assign io_rdata  = rdata_q;
   assign cpu_stall = (stall_q != `EEB_CNT3_ZERO);
   // level ready request
   assign ready_irq = rie_q && global_int_enable && !busy && !flash_selfprog_active;

   // byte storage
   eeb_cell_array u_cells (
      .clock   (clock),
      .wr_en   (prog_done),
      .wr_mode (op_mode_q),
      .wr_addr (op_addr_q),
      .wr_data (op_data_q),
      .rd_addr (addr_q),
      .rd_data (mem_rdata)
   );

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_read_stall_four: assert property (rd_start |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall length wrong");
   a_write_stall_two: assert property (wr_start |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall length wrong");
   a_addr_hi_zero: assert property ((io_rd && reg_hit(io_addr, `EEB_OFS_ADDR_HI)) |=> io_rdata[7:2] == 6'h00)
      else $error("reserved address bits not zero");
   a_read_data_load: assert property (rd_start |=> data_q == $past(mem_rdata))
      else $error("read data not loaded");
   a_mode_locked: assert property ((busy && ctl_wr) |=> pm_q == $past(pm_q))
      else $error("mode changed during write");
   a_mwe_timeout: assert property ((ctl_wr && io_wdata[`EEB_BIT_MWE]) ##1 (!ctl_wr) [*4] |-> mwe_q ##1 !mwe_q)
      else $error("master enable timeout wrong");
   a_no_arm_start: assert property ((wr_req && !mwe_q && !busy) |=> !busy)
      else $error("write started without master enable");
   a_rsv_mode_idle: assert property ((wr_req && mwe_q && !busy && pm_q == EEB_PM_RSV) |=> !busy)
      else $error("reserved mode started a write");
   a_irq_quiet: assert property ((busy || flash_selfprog_active) |-> !ready_irq)
      else $error("ready request during write");
   a_addr_frozen: assert property ((busy && io_wr) |=> addr_q == $past(addr_q))
      else $error("address changed during write");
   a_done_clears: assert property (prog_done |=> !busy ##1 !cpu_stall)
      else $error("strobe not cleared at done");

   c_read: cover property (rd_start ##5 !cpu_stall);
   c_write: cover property (wr_start ##1 busy);
   c_done: cover property (prog_done ##1 !busy);

endmodule

// ---- eeb_controller_test.sv ----
`timescale 1ns/100ps
`include "eeb_map.svh"

module eeb_controller_test
   import eeb_pkg::*;
;
   logic       clock, srst, gie, flash, rc;
   logic [5:0] io_addr;
   logic       io_wr, io_rd, cpu_stall, ready_irq;
   logic [7:0] io_wdata, io_rdata, v, d;
   logic [7:0] mem [1024];
   logic [9:0] a;
   logic [1:0] m;
   int         mismatches, compares, n, k, j;

   // short programming counts keep the run brief
   eeb_controller #(.PROG_RC_ATOMIC(8), .PROG_RC_SPLIT(4)) dut (
      .clock(clock), .srst(srst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
      .global_int_enable(gie), .flash_selfprog_active(flash), .rc_osc(rc), .ready_irq(ready_irq));

   eeb_cpu_model cpu (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata));

   // cpu clock and a free-running slow oscillator
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      rc = 1'b0;
      #7;
      forever #215 rc = ~rc;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // counts cycles of cpu halt after an access
   task automatic stall_n();
      k = 0;
      #1;
      while (cpu_stall === 1'b1 && k < 9) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask

   // polls the strobe bit under a bound
   task automatic wait_idle();
      for (n = 0; n < 100; n++) begin
         cpu.rd(`EEB_OFS_CTRL, v);
         if (v[`EEB_BIT_WE] === 1'b0)
            return;
      end
      mismatches++;
      $display("[FAIL] %0t write never ended", $time);
      results();
   endtask

   task automatic set_addr(input logic [9:0] ad);
      cpu.wr(`EEB_OFS_ADDR_LO, ad[7:0]);
      cpu.wr(`EEB_OFS_ADDR_HI, {6'h00, ad[9:8]});
   endtask

   task automatic fetch(input logic [9:0] ad, output logic [7:0] q);
      set_addr(ad);
      cpu.wr(`EEB_OFS_CTRL, 8'h09);
      stall_n();
      chk(k[7:0], 8'h04, "read stall");
      cpu.rd(`EEB_OFS_DATA, q);
   endtask

   task automatic refused(input logic [7:0] arm, input logic [7:0] stb);
      if (arm != 8'h00)
         cpu.wr(`EEB_OFS_CTRL, arm);
      cpu.wr(`EEB_OFS_CTRL, stb);
      stall_n();
      chk(k[7:0], 8'h00, "refused stall");
      cpu.rd(`EEB_OFS_CTRL, v);
      chk(v & 8'h02, 8'h00, "refused strobe");
   endtask

   function automatic logic [7:0] exp_byte(logic [1:0] md, logic [7:0] old, logic [7:0] nw);
      case (md)
         2'h0: return nw;
         2'h1: return 8'hFF;
         2'h2: return old & nw;
         default: return old;
      endcase
   endfunction

   // main sequence
   initial begin
      srst = 1'b1;
      gie = 1'b1;
      flash = 1'b0;
      mismatches = 0;
      compares = 0;
      n = $urandom(32'hD52B);
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      for (j = 0; j < 5; j++) begin
         cpu.rd(`EEB_OFS_CTRL + j[5:0], v);
         chk(v, 8'h00, "reset value");
      end
      cpu.wr(`EEB_OFS_ADDR_HI, 8'hFF);
      cpu.rd(`EEB_OFS_ADDR_HI, v);
      chk(v, 8'h03, "address high");
      $display("reset test done");
      for (j = 0; j < 9; j++) begin
         if (j % 3 == 0)
            a = (j == 0) ? 10'h3FF : 10'($urandom);
         m = {j[0] ^ (j % 3 == 2), j % 3 == 2};
         m = (j % 3 == 0) ? 2'h0 : (j % 3 == 1) ? 2'h2 : 2'h1;
         d = 8'($urandom);
         set_addr(a);
         cpu.wr(`EEB_OFS_DATA, d);
         cpu.wr(`EEB_OFS_CTRL, {2'h0, m, 4'hC});
         cpu.wr(`EEB_OFS_CTRL, {2'h0, m, 4'hE});
         stall_n();
         chk(k[7:0], 8'h02, "write stall");
         chk({7'h00, ready_irq}, 8'h00, "irq busy");
         cpu.wr(`EEB_OFS_ADDR_LO, ~a[7:0]);
         cpu.wr(`EEB_OFS_CTRL, {2'h0, ~m, 4'h9});
         stall_n();
         chk(k[7:0], 8'h00, "busy read");
         cpu.rd(`EEB_OFS_CTRL, v);
         chk(v, {2'h0, m, 4'hA}, "busy ctrl");
         wait_idle();
         chk({7'h00, ready_irq}, 8'h01, "irq ready");
         cpu.rd(`EEB_OFS_ADDR_LO, v);
         chk(v, a[7:0], "address held");
         mem[a] = exp_byte(m, mem[a], d);
         fetch(a, v);
         chk(v, mem[a], "cell value");
      end
      $display("program test done");
      cpu.wr(`EEB_OFS_CTRL, 8'h0C);
      cpu.rd(`EEB_OFS_CTRL, v);
      chk(v, 8'h0C, "arm set");
      repeat (3) @(posedge clock);
      cpu.rd(`EEB_OFS_CTRL, v);
      chk(v, 8'h08, "arm expired");
      refused(8'h00, 8'h0E);
      // let the enable armed by the last strobe write run out
      repeat (4) @(posedge clock);
      refused(8'h00, 8'h0A);
      refused(8'h3C, 8'h3E);
      @(posedge clock);
      flash <= 1'b1;
      @(posedge clock);
      #1;
      chk({7'h00, ready_irq}, 8'h00, "irq flash");
      refused(8'h0C, 8'h0E);
      @(posedge clock);
      flash <= 1'b0;
      gie <= 1'b0;
      @(posedge clock);
      #1;
      chk({7'h00, ready_irq}, 8'h00, "irq masked");
      gie <= 1'b1;
      fetch(a, v);
      chk(v, mem[a], "cell kept");
      $display("refusal test done");
      cpu.wr(`EEB_OFS_CTRL, 8'h1C);
      cpu.wr(`EEB_OFS_CTRL, 8'h1E);
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      cpu.rd(`EEB_OFS_CTRL, v);
      chk(v, 8'h12, "reset in write");
      wait_idle();
      mem[a] = 8'hFF;
      fetch(a, v);
      chk(v, mem[a], "write survived");
      cpu.wr(`EEB_OFS_CTRL, 8'h20);
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      cpu.rd(`EEB_OFS_CTRL, v);
      chk(v, 8'h00, "mode cleared");
      $display("reset write test done");
      results();
   end
endmodule

// ---- eeb_cpu_model.sv ----
`timescale 1ns/100ps
`include "eeb_map.svh"

module eeb_cpu_model (
   input  wire logic       clock,
   output logic      [5:0] io_addr,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   // idle bus at time zero
   initial begin
      io_addr = 6'h3F;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'hA5;
   end

   // one-cycle store; released lines show the inverse, not the old value
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask

   // one-cycle load; data stands only in the cycle after the taking edge
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      io_addr <= ~a;
      #1;
      d = io_rdata;
   endtask
endmodule

// ---- eeb_map.svh ----
`ifndef EEB_MAP_SVH
`define EEB_MAP_SVH

// i/o register locations
`define EEB_IO_AW        6
`define EEB_OFS_CTRL     6'h1F
`define EEB_OFS_DATA     6'h20
`define EEB_OFS_ADDR_LO  6'h21
`define EEB_OFS_ADDR_HI  6'h22

// control register fields
`define EEB_BIT_RE       0
`define EEB_BIT_WE       1
`define EEB_BIT_MWE      2
`define EEB_BIT_RIE      3
`define EEB_PM_LSB       4
`define EEB_PM_MSB       5

// address layout
`define EEB_ADDR_W       10
`define EEB_DEPTH        1024
`define EEB_HI_BITS      2

// reset values and cell values
`define EEB_BYTE_ZERO    8'h00
`define EEB_BYTE_ERASED  8'hFF
`define EEB_ADDR_RST     10'h000
`define EEB_PM_RST       2'h0

// cpu clock cycle counts
`define EEB_READ_STALL   3'h4
`define EEB_WRITE_STALL  3'h2
`define EEB_MWE_TIMEOUT  3'h4
`define EEB_CNT3_ZERO    3'h0
`define EEB_CNT3_ONE     3'h1

// programming times in microseconds and in rc oscillator cycles
`define EEB_T_ATOMIC_US  3400
`define EEB_T_SPLIT_US   1800
`define EEB_RC_CYCLES    26368
`define EEB_PCNT_W       15
`define EEB_PCNT_ONE     15'h0001

`endif

// ---- eeb_pkg.sv ----
package eeb_pkg;

   // programming mode codes
   typedef enum logic [1:0] {
      EEB_PM_ATOMIC = 2'b00,
      EEB_PM_ERASE  = 2'b01,
      EEB_PM_WRITE  = 2'b10,
      EEB_PM_RSV    = 2'b11
   } eeb_mode_e;

   // programming engine states
   typedef enum logic {
      EEB_IDLE = 1'b0,
      EEB_PROG = 1'b1
   } eeb_state_e;

endpackage
